// [logic/smbam_top.sv]
// apb slave with smbus slave address recognition and data shift byte
`timescale 1ns/1ps
// Contract
// - hw_ack_enable set gives automatic address match and data byte ACK.
// - mask bit 1 compares address bit, mask bit 0 is don't care.
// - with hardware recognition, general_call_enable adds address 0x00.
// - address and mask sit in bits 7:1; bit 0 holds enables.
// - data byte goes out on the data line MSB first.
// - first received bit lands in the data byte MSB.
// - bus values shift in while shifting out; byte ends as bus byte.
// - after lost arbitration the data byte holds what the bus carried.
// - bus leaves the data byte unchanged while the byte flag is set; software writes still land.
// - clock line held low while the byte flag is set.
// - receiver flag before ACK without hardware ACK, after it with.
// - unacknowledged address suppresses slave events until next START.
module smbam_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic irq
);
   // address decode used only by the error path; the read mux compares addresses itself
   function automatic logic smbam_mapped(input logic [11:0] a);
      smbam_mapped = (a == smbam_pkg::ADDR_OWN_ADDR)
         || (a == smbam_pkg::ADDR_ADDR_MASK)
         || (a == smbam_pkg::ADDR_DATA)
         || (a == smbam_pkg::ADDR_CTRL)
         || (a == smbam_pkg::ADDR_IRQ_STAT)
         || (a == smbam_pkg::ADDR_IRQ_CLR)
         || (a == smbam_pkg::ADDR_IRQ_EN);
   endfunction

   // pin synchronisers
   logic scl_meta;
   logic scl_s;
   logic scl_p;
   logic sda_meta;
   logic sda_s;
   logic sda_p;

   // link state
   smbam_pkg::smbam_state_t state;
   smbam_pkg::smbam_state_t next_state;
   logic [3:0] bit_cnt;
   logic [3:0] next_bit_cnt;
   logic [7:0] shift_data_byte;
   logic [7:0] next_shift_data_byte;
   logic byte_flag;
   logic next_byte_flag;
   logic ack_val;
   logic next_ack_val;
   logic ack_rx;
   logic next_ack_rx;
   logic rw;
   logic next_rw;
   logic addr_phase;
   logic next_addr_phase;
   logic next_sda_oe;
   logic [2:0] irq_stat;
   logic [2:0] next_irq_stat;

   // register state
   logic [7:0] own_address_reg;
   logic [7:0] next_own_address_reg;
   logic [7:0] address_mask_reg;
   logic [7:0] next_address_mask_reg;
   logic [2:0] irq_en;
   logic [2:0] next_irq_en;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic wr_take;
   logic rd_phase;
   logic hw_ack_enable;
   logic addr_hit;
   logic [2:0] ev;

   assign scl_rise = scl_s & ~scl_p;
   assign scl_fall = ~scl_s & scl_p;
   assign start_det = scl_s & scl_p & sda_p & ~sda_s;
   assign stop_det = scl_s & scl_p & ~sda_p & sda_s;
   assign wr_take = psel & penable & pwrite & pready;
   assign rd_phase = psel & penable & ~pready;
   assign hw_ack_enable = address_mask_reg[smbam_pkg::FLD_ENABLE];

   smbam_addr_match u_match (
      .rx_addr(shift_data_byte[7:1]),
      .own_address(own_address_reg[smbam_pkg::FLD_ADDR_MSB:
         smbam_pkg::FLD_ADDR_LSB]),
      .address_compare_mask(address_mask_reg[smbam_pkg::FLD_ADDR_MSB:
         smbam_pkg::FLD_ADDR_LSB]),
      .general_call_enable(own_address_reg[smbam_pkg::FLD_ENABLE]),
      .hit(addr_hit)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_meta <= 1'b1;
         scl_s <= 1'b1;
         scl_p <= 1'b1;
         sda_meta <= 1'b1;
         sda_s <= 1'b1;
         sda_p <= 1'b1;
      end else begin
         scl_meta <= scl_in;
         scl_s <= scl_meta;
         scl_p <= scl_s;
         sda_meta <= sda_in;
         sda_s <= sda_meta;
         sda_p <= sda_s;
      end
   end

   // link sequencing, data byte and event flags
   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shift_data_byte = shift_data_byte;
      next_byte_flag = byte_flag;
      next_ack_val = ack_val;
      next_ack_rx = ack_rx;
      next_rw = rw;
      next_addr_phase = addr_phase;
      next_sda_oe = sda_oe;
      ev = 3'h0;
      // software side: writes land only at the completing bus edge
      if (wr_take && (paddr == smbam_pkg::ADDR_DATA)) begin
         next_shift_data_byte = pwdata[7:0];
      end
      if (wr_take && (paddr == smbam_pkg::ADDR_CTRL)) begin
         next_ack_val = pwdata[smbam_pkg::CTRL_ACK];
         if (!pwdata[smbam_pkg::CTRL_FLAG]) begin
            next_byte_flag = 1'b0;
         end
      end
      if (start_det) begin
         next_state = smbam_pkg::ST_ADDR;
         next_bit_cnt = 4'h0;
         next_addr_phase = 1'b1;
         next_sda_oe = 1'b0;
      end else if (stop_det) begin
         if (state != smbam_pkg::ST_IDLE) begin
            ev[smbam_pkg::EV_STOP] = 1'b1;
         end
         next_state = smbam_pkg::ST_IDLE;
         next_sda_oe = 1'b0;
      end else if (!byte_flag) begin
         case (state)
            smbam_pkg::ST_ADDR, smbam_pkg::ST_RX, smbam_pkg::ST_TX: begin
               if (state == smbam_pkg::ST_TX && !scl_s) begin
                  next_sda_oe = (bit_cnt < smbam_pkg::BYTE_BITS)
                     && !shift_data_byte[7];
               end
               if (scl_rise && bit_cnt < smbam_pkg::BYTE_BITS) begin
                  // bus value enters at the LSB and walks up to the MSB
                  next_shift_data_byte = {shift_data_byte[6:0], sda_s};
                  next_bit_cnt = bit_cnt + 4'h1;
               end
               if (scl_fall && bit_cnt == smbam_pkg::BYTE_BITS) begin
                  next_bit_cnt = 4'h0;
                  if (state == smbam_pkg::ST_TX) begin
                     next_sda_oe = 1'b0;
                     next_state = smbam_pkg::ST_TX_ACK;
                  end else if (!hw_ack_enable) begin
                     if (state == smbam_pkg::ST_ADDR) begin
                        next_rw = shift_data_byte[0];
                     end
                     next_byte_flag = 1'b1;
                     ev[smbam_pkg::EV_BYTE] = 1'b1;
                     next_state = smbam_pkg::ST_ACK_WAIT;
                  end else if (state == smbam_pkg::ST_ADDR) begin
                     next_rw = shift_data_byte[0];
                     if (addr_hit) begin
                        next_sda_oe = 1'b1;
                        next_state = smbam_pkg::ST_ACK;
                     end else begin
                        ev[smbam_pkg::EV_NACK] = 1'b1;
                        next_state = smbam_pkg::ST_IDLE;
                     end
                  end else begin
                     next_sda_oe = ack_val;
                     next_state = smbam_pkg::ST_ACK;
                  end
               end
            end
            smbam_pkg::ST_ACK_WAIT: begin
               // flag just cleared by software: drive its decision
               next_sda_oe = ack_val;
               next_state = smbam_pkg::ST_ACK;
            end
            smbam_pkg::ST_ACK: begin
               if (scl_fall) begin
                  next_sda_oe = 1'b0;
                  next_bit_cnt = 4'h0;
                  if (!sda_oe) begin
                     if (addr_phase) begin
                        ev[smbam_pkg::EV_NACK] = 1'b1;
                     end else if (hw_ack_enable) begin
                        // hardware sent a data NACK: the byte event follows
                        next_byte_flag = 1'b1;
                        ev[smbam_pkg::EV_BYTE] = 1'b1;
                     end
                     next_state = smbam_pkg::ST_IDLE;
                  end else begin
                     next_addr_phase = 1'b0;
                     next_state = rw ? smbam_pkg::ST_TX : smbam_pkg::ST_RX;
                     if (hw_ack_enable || rw) begin
                        next_byte_flag = 1'b1;
                        ev[smbam_pkg::EV_BYTE] = 1'b1;
                     end
                  end
               end
            end
            smbam_pkg::ST_TX_ACK: begin
               if (scl_rise) begin
                  next_ack_rx = ~sda_s;
               end
               if (scl_fall) begin
                  next_byte_flag = 1'b1;
                  ev[smbam_pkg::EV_BYTE] = 1'b1;
                  next_state = ack_rx ? smbam_pkg::ST_TX
                     : smbam_pkg::ST_IDLE;
               end
            end
            default: begin
               next_sda_oe = 1'b0;
            end
         endcase
      end
      next_irq_stat = irq_stat;
      if (wr_take && (paddr == smbam_pkg::ADDR_IRQ_CLR)) begin
         next_irq_stat = irq_stat & ~pwdata[2:0];
      end
      // a new event wins over a clear in the same cycle
      next_irq_stat = next_irq_stat | ev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= smbam_pkg::ST_IDLE;
         bit_cnt <= 4'h0;
         shift_data_byte <= smbam_pkg::RST_DATA;
         byte_flag <= 1'b0;
         ack_val <= 1'b0;
         ack_rx <= 1'b0;
         rw <= 1'b0;
         addr_phase <= 1'b0;
         sda_oe <= 1'b0;
         scl_oe <= 1'b0;
         irq_stat <= smbam_pkg::RST_IRQ;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shift_data_byte <= next_shift_data_byte;
         byte_flag <= next_byte_flag;
         ack_val <= next_ack_val;
         ack_rx <= next_ack_rx;
         rw <= next_rw;
         addr_phase <= next_addr_phase;
         sda_oe <= next_sda_oe;
         scl_oe <= next_byte_flag;
         irq_stat <= next_irq_stat;
      end
   end

   // apb register file: one wait state, then the answer
   always_comb begin
      next_own_address_reg = own_address_reg;
      next_address_mask_reg = address_mask_reg;
      next_irq_en = irq_en;
      next_prdata = prdata;
      next_pslverr = 1'b0;
      next_pready = rd_phase;
      if (wr_take) begin
         if (paddr == smbam_pkg::ADDR_OWN_ADDR) begin
            next_own_address_reg = pwdata[7:0];
         end else if (paddr == smbam_pkg::ADDR_ADDR_MASK) begin
            next_address_mask_reg = pwdata[7:0];
         end else if (paddr == smbam_pkg::ADDR_IRQ_EN) begin
            next_irq_en = pwdata[2:0];
         end
      end
      if (rd_phase) begin
         next_pslverr = !smbam_mapped(paddr);
         next_prdata = 32'h0000_0000;
         if (!pwrite) begin
            if (paddr == smbam_pkg::ADDR_OWN_ADDR) begin
               next_prdata[7:0] = own_address_reg;
            end else if (paddr == smbam_pkg::ADDR_ADDR_MASK) begin
               next_prdata[7:0] = address_mask_reg;
            end else if (paddr == smbam_pkg::ADDR_DATA) begin
               next_prdata[7:0] = shift_data_byte;
            end else if (paddr == smbam_pkg::ADDR_CTRL) begin
               next_prdata[3:0] = {rw, ack_rx, ack_val, byte_flag};
            end else if (paddr == smbam_pkg::ADDR_IRQ_STAT) begin
               next_prdata[2:0] = irq_stat;
            end else if (paddr == smbam_pkg::ADDR_IRQ_EN) begin
               next_prdata[2:0] = irq_en;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         own_address_reg <= smbam_pkg::RST_OWN_ADDR;
         address_mask_reg <= smbam_pkg::RST_ADDR_MASK;
         irq_en <= smbam_pkg::RST_IRQ;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq <= 1'b0;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         own_address_reg <= next_own_address_reg;
         address_mask_reg <= next_address_mask_reg;
         irq_en <= next_irq_en;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         irq <= |(next_irq_stat & next_irq_en);
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end
   end
endmodule

// [logic/smbam_pkg.sv]
// constants, register map and state codes of the address match block
package smbam_pkg;
   // printed offsets are register indices; byte address is four times it
   localparam logic [9:0] IDX_OWN_ADDR = 10'h0BA;
   localparam logic [9:0] IDX_ADDR_MASK = 10'h0BB;
   localparam logic [9:0] IDX_DATA = 10'h0C2;
   localparam logic [9:0] IDX_CTRL = 10'h0C0;
   localparam logic [9:0] IDX_IRQ_STAT = 10'h0C3;
   localparam logic [9:0] IDX_IRQ_CLR = 10'h0C4;
   localparam logic [9:0] IDX_IRQ_EN = 10'h0C5;
   localparam logic [11:0] ADDR_OWN_ADDR = {IDX_OWN_ADDR, 2'b00};
   localparam logic [11:0] ADDR_ADDR_MASK = {IDX_ADDR_MASK, 2'b00};
   localparam logic [11:0] ADDR_DATA = {IDX_DATA, 2'b00};
   localparam logic [11:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
   localparam logic [11:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
   localparam logic [11:0] ADDR_IRQ_CLR = {IDX_IRQ_CLR, 2'b00};
   localparam logic [11:0] ADDR_IRQ_EN = {IDX_IRQ_EN, 2'b00};

   localparam logic [7:0] RST_OWN_ADDR = 8'h00;
   localparam logic [7:0] RST_ADDR_MASK = 8'hFE;
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [2:0] RST_IRQ = 3'h0;

   // low bit of own address / mask registers, and address field
   localparam int FLD_ENABLE = 0;
   localparam int FLD_ADDR_LSB = 1;
   localparam int FLD_ADDR_MSB = 7;
   localparam logic [6:0] GENERAL_CALL = 7'h00;

   // control/status register bits
   localparam int CTRL_FLAG = 0;
   localparam int CTRL_ACK = 1;
   localparam int CTRL_ACK_RX = 2;
   localparam int CTRL_RW = 3;

   // interrupt event bits
   localparam int EV_BYTE = 0;
   localparam int EV_STOP = 1;
   localparam int EV_NACK = 2;

   localparam logic [3:0] BYTE_BITS = 4'h8;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_ACK_WAIT = 7'h04,
      ST_ACK = 7'h08,
      ST_RX = 7'h10,
      ST_TX = 7'h20,
      ST_TX_ACK = 7'h40
   } smbam_state_t;
endpackage

// [logic/smbam_addr_match.sv]
// masked slave address comparator with general call recognition
`timescale 1ns/1ps
module smbam_addr_match (
   input wire logic [6:0] rx_addr,
   input wire logic [6:0] own_address,
   input wire logic [6:0] address_compare_mask,
   input wire logic general_call_enable,
   output logic hit
);
   logic masked_eq;
   logic gc_hit;
   // mask bit 1 compares, mask bit 0 is don't care
   assign masked_eq = ((rx_addr ^ own_address) & address_compare_mask)
      == 7'h00;
   assign gc_hit = general_call_enable
      && (rx_addr == smbam_pkg::GENERAL_CALL);
   assign hit = masked_eq | gc_hit;
endmodule

// [test/smbam_chk.sv]
// port level checks of the address match block
`timescale 1ns/1ps
module smbam_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_out,
   input wire logic sda_oe
);
   logic clr;
   assign clr = psel && penable && pready && pwrite && !pwdata[0] &&
      paddr == smbam_pkg::ADDR_CTRL;
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_outs_low; !scl_out && !sda_out; endproperty
   a_outs_low: assert property (p_outs_low) else $error("line driven high");
   property p_one_wait; psel && penable && !pready |=> pready; endproperty
   a_one_wait: assert property (p_one_wait) else $error("pready late");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("pready too long");
   property p_in_access; pready |-> psel && penable; endproperty
   a_in_access: assert property (p_in_access) else $error("stray pready");
   property p_err_ready; pslverr |-> pready; endproperty
   a_err_ready: assert property (p_err_ready) else $error("stray pslverr");
   property p_upper_zero; pready |-> prdata[31:8] == 24'h000000; endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("read data upper bits set");
   property p_hold_scl; scl_oe && !clr && !$past(clr) |=> scl_oe; endproperty
   a_hold_scl: assert property (p_hold_scl)
      else $error("clock released without flag clear");
   property p_sda_low; $changed(sda_oe) |-> !scl_in; endproperty
   a_sda_low: assert property (p_sda_low)
      else $error("data changed while clock high");
endmodule
bind smbam_top smbam_chk u_chk (.pclk(pclk), .presetn(presetn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
   .sda_out(sda_out), .sda_oe(sda_oe));

// [test/smbam_master.sv]
// bus master model pulling the clock and data lines low
`timescale 1ns/1ps
module smbam_master (
   input wire logic pclk,
   input wire logic scl,
   input wire logic sda,
   output logic scl_lo,
   output logic sda_lo
);
   initial begin
      scl_lo = 1'b0;
      sda_lo = 1'b0;
   end
   task w(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task start;
      @(posedge pclk);
      sda_lo <= 1'b1;
      w(4);
      scl_lo <= 1'b1;
   endtask
   task bitx(input logic b, output logic r);
      w(1);
      sda_lo <= !b;
      w(3);
      scl_lo <= 1'b0;
      @(posedge pclk);
      while (scl !== 1'b1) @(posedge pclk);
      w(4);
      r = sda;
      scl_lo <= 1'b1;
   endtask
   task wbyte(input logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(v[i], r);
   endtask
   task rbyte(output logic [7:0] v);
      for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
   endtask
   task stop;
      w(1);
      sda_lo <= 1'b1;
      w(3);
      scl_lo <= 1'b0;
      @(posedge pclk);
      while (scl !== 1'b1) @(posedge pclk);
      w(4);
      sda_lo <= 1'b0;
      w(8);
   endtask
endmodule

// [test/smbus_address_match_data_test.sv]
// self-checking bench of the address match block
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
 $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module smbus_address_match_data_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, a;
   logic scl_out, scl_oe, sda_out, sda_oe, irq, msl, mda;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [7:0] d;
   wire scl, sda;
   int bad_count, checks;
   logic [6:0] t_own [7] = '{7'h34, 7'h34, 7'h34, 7'h34, 7'h34, 7'h70, 7'h70};
   logic [6:0] t_msk [7] = '{7'h7F, 7'h7F, 7'h7F, 7'h7E, 7'h7E, 7'h73, 7'h73};
   logic [6:0] t_adr [7] = '{7'h34, 7'h00, 7'h00, 7'h35, 7'h36, 7'h7C, 7'h71};
   logic [0:6] t_gc = 7'b0010000;
   logic [0:6] t_hit = 7'b1011010;
   assign scl = !(msl || (scl_oe && !scl_out));
   assign sda = !(mda || (sda_oe && !sda_out));
   smbam_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
      .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .irq(irq));
   smbam_master m (.pclk(pclk), .scl(scl), .sda(sda), .scl_lo(msl),
      .sda_lo(mda));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task w(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] ad, input logic [31:0] wd);
      apb(1'b1, ad, wd);
   endtask
   task rd(input logic [11:0] ad);
      apb(1'b0, ad, 32'h00000000);
   endtask
   task wflag;
      for (int i = 0; i < 400 && scl_oe !== 1'b1; i++) @(posedge pclk);
      `CHK(scl_oe, 1'b1)
   endtask
   task t_reset;
      rd(smbam_pkg::ADDR_OWN_ADDR);
      `CHK(rv, 32'h00000000)
      rd(smbam_pkg::ADDR_ADDR_MASK);
      `CHK(rv, 32'h000000FE)
      rd(smbam_pkg::ADDR_DATA);
      `CHK(rv, 32'h00000000)
      rd(12'h004);
      `CHK(er, 1'b1)
   endtask
   task t_match;
      for (int i = 0; i < 7; i++) begin
         wr(smbam_pkg::ADDR_OWN_ADDR, {24'h000000, t_own[i], t_gc[i]});
         wr(smbam_pkg::ADDR_ADDR_MASK, {24'h000000, t_msk[i], 1'b1});
         rd(smbam_pkg::ADDR_OWN_ADDR);
         `CHK(rv[7:0], {t_own[i], t_gc[i]})
         m.start();
         m.wbyte({t_adr[i], 1'b0});
         w(8);
         `CHK(scl_oe, 1'b0)
         m.bitx(1'b1, a);
         `CHK(a, !t_hit[i])
         if (t_hit[i]) begin
            wflag();
            wr(smbam_pkg::ADDR_CTRL, 32'h00000002);
         end else begin
            rd(smbam_pkg::ADDR_IRQ_STAT);
            `CHK(rv[smbam_pkg::EV_NACK], 1'b1)
            m.wbyte(8'h00);
            m.bitx(1'b1, a);
            w(8);
            `CHK(scl_oe, 1'b0)
            wr(smbam_pkg::ADDR_IRQ_CLR, 32'h00000007);
         end
         m.stop();
      end
   endtask
   task t_hw;
      wr(smbam_pkg::ADDR_OWN_ADDR, 32'h00000068);
      wr(smbam_pkg::ADDR_ADDR_MASK, 32'h000000FF);
      wr(smbam_pkg::ADDR_IRQ_EN, 32'h00000001);
      m.start();
      m.wbyte(8'h68);
      m.bitx(1'b1, a);
      wflag();
      w(2);
      `CHK(irq, 1'b1)
      wr(smbam_pkg::ADDR_IRQ_EN, 32'h00000000);
      w(2);
      `CHK(irq, 1'b0)
      wr(smbam_pkg::ADDR_IRQ_EN, 32'h00000001);
      wr(smbam_pkg::ADDR_IRQ_CLR, 32'h00000001);
      w(2);
      `CHK(irq, 1'b0)
      wr(smbam_pkg::ADDR_CTRL, 32'h00000002);
      m.wbyte(8'hA5);
      m.bitx(1'b1, a);
      `CHK(a, 1'b0)
      wflag();
      rd(smbam_pkg::ADDR_DATA);
      `CHK(rv, 32'h000000A5)
      w(30);
      rd(smbam_pkg::ADDR_DATA);
      `CHK(rv, 32'h000000A5)
      wr(smbam_pkg::ADDR_CTRL, 32'h00000000);
      m.wbyte(8'h3C);
      m.bitx(1'b1, a);
      `CHK(a, 1'b1)
      wflag();
      rd(smbam_pkg::ADDR_DATA);
      `CHK(rv, 32'h0000003C)
      wr(smbam_pkg::ADDR_IRQ_EN, 32'h00000000);
      wr(smbam_pkg::ADDR_IRQ_CLR, 32'h00000007);
      wr(smbam_pkg::ADDR_CTRL, 32'h00000002);
      m.stop();
   endtask
   task t_sw;
      wr(smbam_pkg::ADDR_ADDR_MASK, 32'h000000FE);
      wr(smbam_pkg::ADDR_OWN_ADDR, 32'h00000000);
      m.start();
      m.wbyte(8'h22);
      wflag();
      wr(smbam_pkg::ADDR_CTRL, 32'h00000002);
      m.bitx(1'b1, a);
      `CHK(a, 1'b0)
      m.wbyte(8'h5A);
      wflag();
      rd(smbam_pkg::ADDR_DATA);
      `CHK(rv, 32'h0000005A)
      wr(smbam_pkg::ADDR_CTRL, 32'h00000000);
      m.bitx(1'b1, a);
      `CHK(a, 1'b1)
      m.stop();
   endtask
   task t_tx;
      wr(smbam_pkg::ADDR_ADDR_MASK, 32'h000000FF);
      wr(smbam_pkg::ADDR_OWN_ADDR, 32'h00000068);
      m.start();
      m.wbyte(8'h69);
      m.bitx(1'b1, a);
      `CHK(a, 1'b0)
      wflag();
      rd(smbam_pkg::ADDR_CTRL);
      `CHK(rv[smbam_pkg::CTRL_RW], 1'b1)
      wr(smbam_pkg::ADDR_DATA, 32'h00000096);
      wr(smbam_pkg::ADDR_CTRL, 32'h00000002);
      m.rbyte(d);
      `CHK(d, 8'h96)
      m.bitx(1'b1, a);
      wflag();
      rd(smbam_pkg::ADDR_DATA);
      `CHK(rv, 32'h00000096)
      wr(smbam_pkg::ADDR_CTRL, 32'h00000002);
      m.stop();
   endtask
   task t_rerun;
      m.start();
      m.wbyte(8'h68);
      m.bitx(1'b1, a);
      `CHK(a, 1'b0)
      wflag();
      presetn <= 1'b0;
      w(3);
      `CHK(scl_oe, 1'b0)
      `CHK(irq, 1'b0)
      presetn <= 1'b1;
      rd(smbam_pkg::ADDR_ADDR_MASK);
      `CHK(rv, 32'h000000FE)
      rd(smbam_pkg::ADDR_OWN_ADDR);
      `CHK(rv, 32'h00000000)
      rd(smbam_pkg::ADDR_CTRL);
      `CHK(rv, 32'h00000000)
      m.stop();
   endtask
   task final_report;
      $display("checks %0d errors %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #500000;
      bad_count++;
      final_report();
   end
   initial begin
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      bad_count = 0;
      checks = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_match();
      t_hw();
      t_sw();
      t_tx();
      t_rerun();
      final_report();
   end
endmodule
